// *** src/rscmb_top.sv ***
// Reset source combiner with cause register behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module rscmb_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire rscmb_pkg::rscmb_src_t sources,
  input  wire logic               external_clear_pin_n,
  input  wire logic               watchdog_config_enable,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    master_reset_out,
  output logic                    watchdog_enable,
  output logic                    regulator_sleep_keep,
  output logic                    irq
);

  // Merge a 16-bit register with byte-lane write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Lane mask for write-one-to-clear
  function automatic logic [15:0] lane_ones(input logic [31:0] data,
                                            input logic [3:0]  strb);
    return {data[15:8] & {8{strb[1]}}, data[7:0] & {8{strb[0]}}};
  endfunction

  function automatic logic addr_ok(input logic [3:0] a);
    return (a == rscmb_pkg::ADDR_CAUSE) || (a == rscmb_pkg::ADDR_IRQ_ST) ||
           (a == rscmb_pkg::ADDR_IRQ_MSK);
  endfunction

  logic                awready_q;
  logic                wready_q;
  logic                aw_have_q;
  logic                w_have_q;
  logic [3:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic [15:0]         cause_q;
  logic [15:0]         cause_d;
  logic [15:0]         irq_st_q;
  logic [15:0]         irq_st_d;
  logic [15:0]         irq_msk_q;
  logic                master_reset_q;
  logic                wdt_en_q;
  logic                vreg_keep_q;
  logic                irq_q;
  logic                do_wr;
  logic                wr_cause;
  logic                wr_irq_st;
  logic                wr_irq_msk;
  logic                any_source;
  logic [15:0]         hw_set;

  assign do_wr      = aw_have_q && w_have_q && !bvalid_q;
  assign wr_cause   = do_wr && (awaddr_q == rscmb_pkg::ADDR_CAUSE);
  assign wr_irq_st  = do_wr && (awaddr_q == rscmb_pkg::ADDR_IRQ_ST);
  assign wr_irq_msk = do_wr && (awaddr_q == rscmb_pkg::ADDR_IRQ_MSK);

  // Reset sources; the clear pin is active low
  assign any_source = sources.power_on || sources.brownout ||
                      !external_clear_pin_n || sources.soft_reset ||
                      sources.watchdog_timeout || sources.config_mismatch ||
                      sources.trap_conflict || sources.illegal_condition;

  // Hardware flag sets, one per cause
  always_comb begin
    hw_set                          = 16'h0000;
    hw_set[rscmb_pkg::BIT_TRAP]     = sources.trap_conflict;
    hw_set[rscmb_pkg::BIT_ILLEGAL]  = sources.illegal_condition;
    hw_set[rscmb_pkg::BIT_CFG_MISMATCH] = sources.config_mismatch;
    hw_set[rscmb_pkg::BIT_EXT]      = !external_clear_pin_n;
    hw_set[rscmb_pkg::BIT_SOFT_RST] = sources.soft_reset;
    hw_set[rscmb_pkg::BIT_WDT_TIMEOUT] = sources.watchdog_timeout;
    hw_set[rscmb_pkg::BIT_SLEEP]    = sources.sleep_wake;
    hw_set[rscmb_pkg::BIT_IDLE]     = sources.idle_wake;
    hw_set[rscmb_pkg::BIT_BROWNOUT] = sources.brownout;
    hw_set[rscmb_pkg::BIT_POR]      = sources.power_on;
  end

  // Cause register: hardware set wins over a software clear in one cycle
  always_comb begin
    if (sources.power_on) begin
      cause_d = rscmb_pkg::CAUSE_POR;
    end else begin
      cause_d = cause_q;
      if (wr_cause) begin
        // Software writes only store; they never feed the reset path
        cause_d = lane_merge(cause_q, wdata_q, wstrb_q);
      end
      cause_d = (cause_d | hw_set) & rscmb_pkg::CAUSE_IMPL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= rscmb_pkg::CAUSE_POR;
    end else begin
      cause_q <= cause_d;
    end
  end

  // Interrupt status, sticky per cause flag, write one to clear
  always_comb begin
    irq_st_d = irq_st_q;
    if (wr_irq_st) begin
      irq_st_d = irq_st_q & ~lane_ones(wdata_q, wstrb_q);
    end
    irq_st_d = irq_st_d | (hw_set & rscmb_pkg::CAUSE_FLAGS);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= 16'h0000;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_msk_q <= rscmb_pkg::IRQ_MSK_RST;
    end else if (wr_irq_msk) begin
      irq_msk_q <= lane_merge(irq_msk_q, wdata_q, wstrb_q) &
                   rscmb_pkg::CAUSE_FLAGS;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  // Master reset held from reset release until every source is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_reset_q <= 1'b1;
    end else begin
      master_reset_q <= any_source;
    end
  end

  // Control outputs derived from the control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_en_q    <= 1'b0;
      vreg_keep_q <= 1'b0;
    end else begin
      wdt_en_q    <= cause_q[rscmb_pkg::BIT_WDTEN] ||
                     watchdog_config_enable;
      vreg_keep_q <= cause_q[rscmb_pkg::BIT_VREG];
    end
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q  <= 4'h0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q  <= {s_axi_awaddr[3:2], 2'b00};
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= rscmb_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_ok(awaddr_q) ? rscmb_pkg::RESP_OKAY
                                    : rscmb_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= rscmb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= addr_ok({s_axi_araddr[3:2], 2'b00}) ?
                   rscmb_pkg::RESP_OKAY : rscmb_pkg::RESP_SLVERR;
      unique case ({s_axi_araddr[3:2], 2'b00})
        rscmb_pkg::ADDR_CAUSE:   rdata_q <= {16'h0000, cause_q};
        rscmb_pkg::ADDR_IRQ_ST:  rdata_q <= {16'h0000, irq_st_q};
        rscmb_pkg::ADDR_IRQ_MSK: rdata_q <= {16'h0000, irq_msk_q};
        default:                 rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready        = awready_q;
  assign s_axi_wready         = wready_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = arready_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign master_reset_out     = master_reset_q;
  assign watchdog_enable      = wdt_en_q;
  assign regulator_sleep_keep = vreg_keep_q;
  assign irq                  = irq_q;

endmodule
`default_nettype wire

// *** src/rscmb_pkg.sv ***
// Constants and types shared by the reset source combiner
// Overview of operation
// - Master reset output is asserted while any reset source is active.
// - Every reset kind sets its own cause flag in the status register.
// - Power-on reset clears all status flags and sets the power-on flag.
// - Software may set or clear any flag; setting never causes a reset.
// - Bit 15 is set by a trap conflict reset or by a software write.
// - Bit 14 is set by an illegal opcode, address mode or pointer reset.
// - Bits 13 down to 10 are unimplemented and always read zero.
// - Bit 9 is set by a configuration mismatch reset.
// - Bit 8 high keeps the regulator active in sleep; low lets it stand by.
// - Bit 7 is set by a reset from the external clear pin.
// - Bit 6 is set when a software reset instruction executes.
// - Bit 5 enables the watchdog; the configuration enable overrides it.
// - Bit 4 is set by a watchdog time-out.
// - Bit 3 is set after the device has been in sleep.
// - Bit 2 is set after the device has been in idle.
// - Bit 1 is set by a brown-out reset.
// - Bit 0 is set by a power-on reset.
package rscmb_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CAUSE   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h8;
  localparam int         ADDR_W       = 4;

  // Field positions of reset_cause_status
  localparam int BIT_TRAP    = 15;
  localparam int BIT_ILLEGAL = 14;
  localparam int BIT_CFG_MISMATCH = 9;
  localparam int BIT_VREG    = 8;
  localparam int BIT_EXT     = 7;
  localparam int BIT_SOFT_RST = 6;
  localparam int BIT_WDTEN   = 5;
  localparam int BIT_WDT_TIMEOUT = 4;
  localparam int BIT_SLEEP   = 3;
  localparam int BIT_IDLE    = 2;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_POR     = 0;

  // Implemented bits, cause flags only, and the value after power-on
  localparam logic [15:0] CAUSE_IMPL  = 16'hc3ff;
  localparam logic [15:0] CAUSE_FLAGS = 16'hc2df;
  localparam logic [15:0] CAUSE_POR   = 16'h0001;
  localparam logic [15:0] IRQ_MSK_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset source detectors and power-state events, all active high
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic soft_reset;
    logic watchdog_timeout;
    logic config_mismatch;
    logic trap_conflict;
    logic illegal_condition;
    logic sleep_wake;
    logic idle_wake;
  } rscmb_src_t;

endpackage

// *** tb/rscmb_src_mdl.sv ***
// Behavioural model of the reset source detectors and the clear pin
`timescale 1ns/1ns
`default_nettype none
module rscmb_src_mdl (
  input  wire logic            aclk,
  input  wire logic [9:0]      req,
  input  wire logic [2:0]      len,
  output var rscmb_pkg::rscmb_src_t sources,
  output logic                 external_clear_pin_n
);
  logic [9:0] hold_q = 10'h0;
  logic [2:0] cnt_q = 3'h0;

  // A detector holds its line for len + 1 cycles: a slow one for several, a fast one with len 1 for two
  always @(posedge aclk) begin
    if (req != 10'h0) begin
      hold_q <= req;
      cnt_q <= len;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      hold_q <= 10'h0;
    end
  end

  assign sources = rscmb_pkg::rscmb_src_t'(hold_q[8:0]);
  // The pin is active low, so an idle detector leaves it high
  assign external_clear_pin_n = ~hold_q[9];
endmodule
`default_nettype wire

// *** tb/rscmb_chk.sv ***
// Concurrent checks on the ports of the reset source combiner
`timescale 1ns/1ns
`default_nettype none
module rscmb_chk (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire rscmb_pkg::rscmb_src_t sources,
  input wire logic                  external_clear_pin_n,
  input wire logic                  watchdog_config_enable,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  master_reset_out,
  input wire logic                  watchdog_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rst_any: assert property (
    (sources.power_on || sources.brownout || sources.soft_reset ||
     sources.watchdog_timeout || sources.config_mismatch ||
     sources.trap_conflict || sources.illegal_condition ||
     !external_clear_pin_n) |=> master_reset_out)
    else $error("master reset missing while a source is active");
  a_rst_free: assert property (
    (!(sources.power_on || sources.brownout || sources.soft_reset ||
       sources.watchdog_timeout || sources.config_mismatch ||
       sources.trap_conflict || sources.illegal_condition) &&
     external_clear_pin_n) |=> !master_reset_out)
    else $error("master reset held with no source active");
  a_wdt_force: assert property (
    watchdog_config_enable |=> watchdog_enable)
    else $error("watchdog off while the configuration forces it on");
  a_rd_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0
      && s_axi_rdata[13:10] == 4'h0)
    else $error("unimplemented read bits not zero");
  a_b_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn after handshake");
  a_r_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not back to idle after handshake");
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address taken");
  a_aw_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is pending");
endmodule

bind rscmb_top rscmb_chk u_chk (.aclk, .aresetn, .sources,
  .external_clear_pin_n, .watchdog_config_enable, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .master_reset_out, .watchdog_enable);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the reset source combiner
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, watchdog_config_enable = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, external_clear_pin_n, master_reset_out;
  logic        watchdog_enable, regulator_sleep_keep, irq;
  logic [9:0]  req = 10'h0;
  logic [2:0]  len = 3'h1;
  rscmb_pkg::rscmb_src_t sources;
  int          bad_count = 0, cmp_count = 0;

  always #20 aclk = ~aclk;

  rscmb_src_mdl u_src (.aclk, .req, .len, .sources, .external_clear_pin_n);
  rscmb_top dut (.aclk, .aresetn, .sources, .external_clear_pin_n,
    .watchdog_config_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_reset_out, .watchdog_enable, .regulator_sleep_keep, .irq);

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Ready is sampled before the edge's own updates land
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge aclk);
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        r = s_axi_rresp;
        q = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      $display("BAD bus_answer expected response seen none");
      close_out();
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0);
    cmp("rresp", 32'h0, {30'h0, r});
    cmp("rdata", e, q);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
    cmp("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic fire(input int i, input logic [2:0] n);
    @(posedge aclk);
    req <= 10'h1 << i;
    len <= n;
    @(posedge aclk);
    req <= 10'h0;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic src_case(input int i, input int b);
    fire(i, i[0] ? 3'h3 : 3'h1);
    // Sleep and idle wake-ups are flags only, not reset sources
    cmp1("master_reset_out", i > 1, master_reset_out);
    repeat (7) @(posedge aclk);
    #1;
    cmp1("master_reset_out", 1'b0, master_reset_out);
    cmp1("irq", 1'b0, irq);
    rd(rscmb_pkg::ADDR_CAUSE, 32'h1 << b);
    wr(rscmb_pkg::ADDR_CAUSE, 16'h0);
    $display("test source %0d done", i);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    cmp1("master_reset_out", 1'b1, master_reset_out);
    rd(rscmb_pkg::ADDR_CAUSE, 32'h1);
    s_axi_wstrb <= 4'h1;
    wr(rscmb_pkg::ADDR_CAUSE, 16'hffff);
    rd(rscmb_pkg::ADDR_CAUSE, 32'hff);
    s_axi_wstrb <= 4'h3;
    wr(rscmb_pkg::ADDR_CAUSE, 16'hffff);
    rd(rscmb_pkg::ADDR_CAUSE, 32'hc3ff);
    cmp1("master_reset_out", 1'b0, master_reset_out);
    cmp1("irq", 1'b0, irq);
    cmp1("watchdog_enable", 1'b1, watchdog_enable);
    cmp1("regulator_sleep_keep", 1'b1, regulator_sleep_keep);
    fire(8, 3'h1);
    repeat (6) @(posedge aclk);
    rd(rscmb_pkg::ADDR_CAUSE, 32'h1);
    cmp1("watchdog_enable", 1'b0, watchdog_enable);
    cmp1("regulator_sleep_keep", 1'b0, regulator_sleep_keep);
    watchdog_config_enable <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp1("watchdog_enable", 1'b1, watchdog_enable);
    watchdog_config_enable <= 1'b0;
    wr(rscmb_pkg::ADDR_CAUSE, 16'h0);
    $display("test software access done");
    src_case(0, 2);
    src_case(1, 3);
    src_case(2, 14);
    src_case(3, 15);
    src_case(4, 9);
    src_case(5, 4);
    src_case(6, 6);
    src_case(7, 1);
    src_case(9, 7);
    // Masked events above left status bits behind
    wr(rscmb_pkg::ADDR_IRQ_ST, 16'hffff);
    wr(rscmb_pkg::ADDR_IRQ_MSK, 16'hffff);
    rd(rscmb_pkg::ADDR_IRQ_MSK, 32'hc2df);
    fire(3, 3'h1);
    repeat (7) @(posedge aclk);
    #1;
    cmp1("irq", 1'b1, irq);
    rd(rscmb_pkg::ADDR_IRQ_ST, 32'h8000);
    wr(rscmb_pkg::ADDR_IRQ_ST, 16'h8000);
    repeat (2) @(posedge aclk);
    #1;
    cmp1("irq", 1'b0, irq);
    $display("test interrupt done");
    bus(1'b0, 4'hc, 16'h0);
    cmp("rresp", 32'h2, {30'h0, r});
    cmp("rdata", 32'h0, q);
    bus(1'b1, 4'hc, 16'h1234);
    cmp("bresp", 32'h2, {30'h0, r});
    $display("test unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
